// ==== design/uim_defs.vh ====
// Purpose: Offsets, field positions and reset values for the USB status bank.
// Assumes: Byte offsets of 32-bit registers on the peripheral register port.
// Notes:   Definitions only; included by bare name.
`ifndef UIM_DEFS_VH
`define UIM_DEFS_VH

// Register byte offsets.
`define UIM_OFF_OTG_STATUS_MIRROR     8'h14
`define UIM_OFF_SERIAL_LINE_CONTROL   8'h18
`define UIM_OFF_LINE_EVENT_FLAGS      8'h1C
`define UIM_OFF_FLAG_HOLD_SELECT      8'h20
`define UIM_OFF_EVENT_PORT_MASKS      8'h24
`define UIM_OFF_FRAME_START_COUNTER   8'h28
`define UIM_OFF_LAST_PACKET_ID        8'h2C
`define UIM_OFF_LAST_ENDPOINT         8'h30
`define UIM_OFF_SPECIAL_ENDPOINT_SEL  8'h34
`define UIM_OFF_OTG_STATUS_MASK       8'h38
`define UIM_OFF_POWER_SIGNALLING      8'h3C

// Serial line control fields.
`define UIM_SER_RX_RCV_BIT            6
`define UIM_SER_RX_DM_BIT             5
`define UIM_SER_RX_DP_BIT             4
`define UIM_SER_TX_SE0_BIT            3
`define UIM_SER_TX_DATA_BIT           2
`define UIM_SER_TX_ENABLE_N_BIT       1
`define UIM_SER_FSLS_MODE_BIT         0
`define UIM_SER_RESET                 4'h2

// Line event flag positions.
`define UIM_FLG_TOKEN_DECODED         6
`define UIM_FLG_LINE_SE0              5
`define UIM_FLG_LINE_K                4
`define UIM_FLG_LINE_J                3
`define UIM_FLG_DATA_CRC_FAIL         2
`define UIM_FLG_RECEIVE_ACTIVE        1
`define UIM_FLG_RECEIVE_ERROR         0
`define UIM_FLAG_COUNT                7

// Line state codes as the transceiver reports them.
`define UIM_LINE_SE0                  2'h0
`define UIM_LINE_J                    2'h1
`define UIM_LINE_K                    2'h2

// Field positions of other registers.
`define UIM_ENDPOINT_VALID_BIT        4
`define UIM_SPECIAL_TAG               5'h10
`define UIM_POWER_VALID_BIT           8
`define UIM_RESET_ZERO                32'h00000000

`endif

// ==== design/uim_flag_cell.v ====
// Purpose: One line event flag with selectable hold behaviour.
// Assumes: cond is synchronous; packet_start is a one-cycle pulse.
// Notes:   Set wins over a software clear arriving in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module uim_flag_cell
#(
  parameter LEVEL = 0
)
(
  // Clock and reset.
  input  wire clock,
  input  wire rst,
  // Controls.
  input  wire hold,
  input  wire cond,
  input  wire packet_start,
  input  wire sw_clear,
  // Flag value.
  output reg  flag
);

  // A held flag only falls on a software clear; a free flag tracks its
  // source, and event flags fall again at the start of the next packet.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      flag <= 1'b0;
    else if (cond)
      flag <= 1'b1;                                // [R7] [R8] [R9] [R10]
    else if (hold)
      flag <= sw_clear ? 1'b0 : flag;              // [R11]
    else if (LEVEL != 0)
      flag <= 1'b0;                                // [R12]
    else if (packet_start || sw_clear)
      flag <= 1'b0;                                // [R6]
  end

endmodule // uim_flag_cell

`default_nettype wire

// ==== design/uim_endpoint_capture.v ====
// Purpose: Captures the last packet identifier and endpoint number.
// Assumes: Strobes come from the packet decoder on the same clock.
// Notes:   The tagged endpoint output is registered with the capture.
`timescale 1ns/1ps
`default_nettype none
`include "uim_defs.vh"

module uim_endpoint_capture
(
  // Clock and reset.
  input  wire        clock,
  input  wire        rst,
  // Packet decoder strobes.
  input  wire        pid_strobe,
  input  wire [3:0]  pid_value,
  input  wire        endpoint_strobe,
  input  wire [3:0]  endpoint_value,
  // Special endpoint selection.
  input  wire [15:0] special_endpoint_bits,
  // Captured values.
  output reg  [3:0]  last_packet_id_field,
  output reg  [3:0]  endpoint_number_field,
  output reg         endpoint_valid_bit,
  output reg  [4:0]  rx_endpoint_tag
);

  // Capture on each strobe; the special mark is decided from the mask in
  // force at capture time, so a later mask write does not retag it.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      last_packet_id_field  <= 4'h0;
      endpoint_number_field <= 4'h0;
      endpoint_valid_bit    <= 1'b0;
      rx_endpoint_tag       <= 5'h00;
    end
    else
    begin
      if (pid_strobe)
        last_packet_id_field <= pid_value;                       // [R15]
      if (endpoint_strobe)
      begin
        endpoint_number_field <= endpoint_value;                 // [R16]
        endpoint_valid_bit    <= 1'b1;                           // [R16]
        rx_endpoint_tag       <= {special_endpoint_bits[endpoint_value],
                                  endpoint_value};               // [R17]
      end
    end
  end

endmodule // uim_endpoint_capture

`default_nettype wire

// ==== design/uim_status_bank.v ====
// Purpose: Status, flag and capture registers of the USB interface module.
// Assumes: 200 MHz clock; full 32-bit register reads and writes.
// Notes:   Transceiver inputs are pins and pass a two-flop synchroniser.
//
// How it works
// [R1] OTG status register mirrors six live transceiver session and id flags.
// [R2] Serial control bits 6..4 show differential, D-minus and D-plus receive.
// [R3] Serial control bits 3 and 2 drive SE0 transmit and transmit data.
// [R4] Serial control bit 1 drives active-low transmit enable, reset to one.
// [R5] Serial control bit 0 selects full/low-speed serial mode when set.
// [R6] Non-sticky event flags clear when the next packet begins.
// [R7] Flag 6 sets when a token passes CRC5, PID and address checks.
// [R8] Flags 5, 4, 3 set on SE0, K and J line states.
// [R9] Flag 2 sets when a data packet fails its CRC16 check.
// [R10] Flag 1 follows receive active; flag 0 follows receive error.
// [R11] Sticky flags hold until software writes one to their position.
// [R12] Non-sticky flags are overwritten by later signal changes.
// [R13] Four 8-bit masks OR selected flags onto four event ports.
// [R14] Frame counter is an 11-bit read/write value split 10:8 and 7:0.
// [R15] Last packet identifier is captured in a read-only 4-bit field.
// [R16] Last endpoint held in bits 3:0 with a valid bit at 4.
// [R17] Special endpoints are delivered on the receive port ORed with 0x10.
// [R18] Software uses only full 32-bit reads and writes.
// [R19] Power signalling holds 8 data bits plus valid; OTG mask is 32 bits.
// [R20] Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "uim_defs.vh"

module uim_status_bank
(
  // Clock and reset.
  input  wire        clock,
  input  wire        rst,
  // Peripheral register port, full 32-bit words only.
  input  wire [7:0]  reg_addr,
  input  wire        reg_write,
  input  wire [31:0] reg_wdata,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  output reg         reg_rvalid,
  // Transceiver on-the-go status pins.
  input  wire        utmi_session_end,
  input  wire        utmi_session_valid,
  input  wire        utmi_vbus_valid,
  input  wire        utmi_host_disconnect,
  input  wire        utmi_id_ground,
  input  wire        utmi_b_valid,
  // Transceiver receive pins.
  input  wire        utmi_rx_rcv,
  input  wire        utmi_rx_dm,
  input  wire        utmi_rx_dp,
  input  wire [1:0]  utmi_line_state,
  input  wire        utmi_rx_active,
  input  wire        utmi_rx_error,
  // Transceiver serial transmit controls.
  output wire        utmi_tx_se0,
  output wire        utmi_tx_data,
  output wire        utmi_tx_enable_n,
  output wire        utmi_fsls_serial,
  // Packet decoder strobes, same clock.
  input  wire        packet_start,
  input  wire        token_strobe,
  input  wire        token_crc5_ok,
  input  wire        token_pid_ok,
  input  wire [6:0]  token_address,
  input  wire [6:0]  device_address,
  input  wire        data_crc16_fail,
  input  wire        pid_strobe,
  input  wire [3:0]  pid_value,
  input  wire        endpoint_strobe,
  input  wire [3:0]  endpoint_value,
  // Frame counter load from a received start-of-frame.
  input  wire        frame_strobe,
  input  wire [10:0] frame_number,
  // Event ports driven by the masked flags.
  output reg         event_port_a,
  output reg         event_port_b,
  output reg         event_port_c,
  output reg         event_port_d,
  // Receive endpoint port and register copies for neighbouring logic.
  output wire [4:0]  rx_endpoint_tag,
  output wire [10:0] frame_count,
  output wire [31:0] otg_mask_value,
  output wire [7:0]  power_signal_data,
  output wire        power_signal_valid
);

  // Address decode helper used by the write strobes; the read path decodes with a case.
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // Masked OR of the flags for one event port field.
  function port_level;
    input [7:0] mask_field;
    input [6:0] flags;
    begin
      port_level = |(mask_field[6:0] & flags);
    end
  endfunction

  // Synchroniser stages for the thirteen transceiver pins.
  localparam SYNC_WIDTH = 13;
  reg  [SYNC_WIDTH-1:0] sync_stage1;
  reg  [SYNC_WIDTH-1:0] sync_stage2;
  wire [SYNC_WIDTH-1:0] pin_vector;
  // Software visible storage.
  reg  [3:0]  serial_line_control;
  reg  [6:0]  flag_hold_bits;
  reg  [31:0] event_port_masks;
  reg  [10:0] frame_counter;
  reg  [15:0] special_endpoint_bits;
  reg  [31:0] otg_mask_reg;
  reg  [7:0]  power_data_reg;
  reg         power_valid_reg;
  // Decoded write strobes.
  wire        wr_serial;
  wire        wr_flags;
  wire        wr_hold;
  wire        wr_masks;
  wire        wr_frame;
  wire        wr_special;
  wire        wr_otg_mask;
  wire        wr_power;
  // Synchronised line state for the symbol decode.
  wire [1:0]  line_state_sync;
  // Flag conditions and flag values.
  wire [6:0]  flag_cond;
  wire [6:0]  line_event_flags;
  wire        token_match;
  // Captured packet values.
  wire [3:0]  last_packet_id_field;
  wire [3:0]  endpoint_number_field;
  wire        endpoint_valid_bit;
  // Read multiplexer result.
  reg  [31:0] next_rdata;

  // Pin order inside the synchroniser vector.
  assign pin_vector = {utmi_b_valid, utmi_id_ground, utmi_host_disconnect,
                       utmi_vbus_valid, utmi_session_valid, utmi_session_end,
                       utmi_rx_rcv, utmi_rx_dm, utmi_rx_dp,
                       utmi_line_state, utmi_rx_active, utmi_rx_error};

  // Two flops per pin; only the second stage feeds any logic.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_stage1 <= 13'h0000;
      sync_stage2 <= 13'h0000;
    end
    else
    begin
      sync_stage1 <= pin_vector;
      sync_stage2 <= sync_stage1;
    end
  end

  // Line state view; the other synchronised bits are read in place.
  assign line_state_sync = sync_stage2[3:2];

  // Write strobes; software always writes a whole word.
  assign wr_serial   = reg_write && hit(reg_addr,
                                        `UIM_OFF_SERIAL_LINE_CONTROL);
  assign wr_flags    = reg_write && hit(reg_addr, `UIM_OFF_LINE_EVENT_FLAGS);
  assign wr_hold     = reg_write && hit(reg_addr, `UIM_OFF_FLAG_HOLD_SELECT);
  assign wr_masks    = reg_write && hit(reg_addr, `UIM_OFF_EVENT_PORT_MASKS);
  assign wr_frame    = reg_write && hit(reg_addr,
                                        `UIM_OFF_FRAME_START_COUNTER);
  assign wr_special  = reg_write && hit(reg_addr,
                                        `UIM_OFF_SPECIAL_ENDPOINT_SEL);
  assign wr_otg_mask = reg_write && hit(reg_addr, `UIM_OFF_OTG_STATUS_MASK);
  assign wr_power    = reg_write && hit(reg_addr, `UIM_OFF_POWER_SIGNALLING);

  // Writable registers; bits beyond each field are simply not stored.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      serial_line_control   <= `UIM_SER_RESET;                  // [R4]
      flag_hold_bits        <= 7'h00;
      event_port_masks      <= `UIM_RESET_ZERO;
      special_endpoint_bits <= 16'h0000;
      otg_mask_reg          <= `UIM_RESET_ZERO;
      power_data_reg        <= 8'h00;
      power_valid_reg       <= 1'b0;
    end
    else
    begin
      if (wr_serial)
        serial_line_control <= reg_wdata[3:0];                  // [R20]
      if (wr_hold)
        flag_hold_bits <= reg_wdata[6:0];                       // [R11]
      if (wr_masks)
        event_port_masks <= reg_wdata;                          // [R13]
      if (wr_special)
        special_endpoint_bits <= reg_wdata[15:0];               // [R17]
      if (wr_otg_mask)
        otg_mask_reg <= reg_wdata;                              // [R19]
      if (wr_power)
      begin
        power_data_reg  <= reg_wdata[7:0];                      // [R19]
        power_valid_reg <= reg_wdata[`UIM_POWER_VALID_BIT];     // [R19]
      end
    end
  end

  // Transmit controls come straight from the register, no extra delay.
  assign utmi_tx_se0      = serial_line_control[`UIM_SER_TX_SE0_BIT];  // [R3]
  assign utmi_tx_data     = serial_line_control[`UIM_SER_TX_DATA_BIT]; // [R3]
  assign utmi_tx_enable_n =
         serial_line_control[`UIM_SER_TX_ENABLE_N_BIT];                // [R4]
  assign utmi_fsls_serial = serial_line_control[`UIM_SER_FSLS_MODE_BIT];
                                                                       // [R5]

  // A received start-of-frame load beats a software write in one cycle.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      frame_counter <= 11'h000;
    else if (frame_strobe)
      frame_counter <= frame_number;                            // [R14]
    else if (wr_frame)
      frame_counter <= reg_wdata[10:0];                         // [R14]
  end

  // A token counts only if every check passes and it is addressed to us.
  assign token_match = token_strobe && token_crc5_ok && token_pid_ok &&
                       (token_address == device_address);       // [R7]

  // Flag source conditions; the line decode uses synchronised state.
  assign flag_cond[`UIM_FLG_TOKEN_DECODED]  = token_match;       // [R7]
  assign flag_cond[`UIM_FLG_LINE_SE0]       =
         (line_state_sync == `UIM_LINE_SE0);                     // [R8]
  assign flag_cond[`UIM_FLG_LINE_K]         =
         (line_state_sync == `UIM_LINE_K);                       // [R8]
  assign flag_cond[`UIM_FLG_LINE_J]         =
         (line_state_sync == `UIM_LINE_J);                       // [R8]
  assign flag_cond[`UIM_FLG_DATA_CRC_FAIL]  = data_crc16_fail;   // [R9]
  assign flag_cond[`UIM_FLG_RECEIVE_ACTIVE] = sync_stage2[1];    // [R10]
  assign flag_cond[`UIM_FLG_RECEIVE_ERROR]  = sync_stage2[0];    // [R10]

  // Line and receive flags are levels; token and CRC flags are events.
  genvar fi;
  generate
    for (fi = 0; fi < `UIM_FLAG_COUNT; fi = fi + 1)
    begin : g_flag
      uim_flag_cell
      #(
        .LEVEL ((fi == `UIM_FLG_TOKEN_DECODED ||
                 fi == `UIM_FLG_DATA_CRC_FAIL) ? 0 : 1)
      )
      u_cell
      (
        .clock        (clock),
        .rst          (rst),
        .hold         (flag_hold_bits[fi]),
        .cond         (flag_cond[fi]),
        .packet_start (packet_start),
        .sw_clear     (wr_flags && reg_wdata[fi]),
        .flag         (line_event_flags[fi])
      );
    end
  endgenerate

  // Event ports are registered so they change one edge after the flags.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      event_port_a <= 1'b0;
      event_port_b <= 1'b0;
      event_port_c <= 1'b0;
      event_port_d <= 1'b0;
    end
    else
    begin
      event_port_a <= port_level(event_port_masks[7:0],
                                 line_event_flags);              // [R13]
      event_port_b <= port_level(event_port_masks[15:8],
                                 line_event_flags);              // [R13]
      event_port_c <= port_level(event_port_masks[23:16],
                                 line_event_flags);              // [R13]
      event_port_d <= port_level(event_port_masks[31:24],
                                 line_event_flags);              // [R13]
    end
  end

  // Packet identifier and endpoint capture with special tagging.
  uim_endpoint_capture u_capture
  (
    .clock                 (clock),
    .rst                   (rst),
    .pid_strobe            (pid_strobe),
    .pid_value             (pid_value),
    .endpoint_strobe       (endpoint_strobe),
    .endpoint_value        (endpoint_value),
    .special_endpoint_bits (special_endpoint_bits),
    .last_packet_id_field  (last_packet_id_field),
    .endpoint_number_field (endpoint_number_field),
    .endpoint_valid_bit    (endpoint_valid_bit),
    .rx_endpoint_tag       (rx_endpoint_tag)
  );

  // Register copies for neighbouring logic.
  assign frame_count        = frame_counter;
  assign otg_mask_value     = otg_mask_reg;
  assign power_signal_data  = power_data_reg;
  assign power_signal_valid = power_valid_reg;

  // Read multiplexer; unmapped offsets and reserved bits return zero.
  always @*
  begin
    next_rdata = `UIM_RESET_ZERO;                                // [R20]
    case (reg_addr)
      `UIM_OFF_OTG_STATUS_MIRROR:
        next_rdata[5:0] = sync_stage2[12:7];                     // [R1]
      `UIM_OFF_SERIAL_LINE_CONTROL:
      begin
        next_rdata[6:4] = sync_stage2[6:4];                      // [R2]
        next_rdata[3:0] = serial_line_control;
      end
      `UIM_OFF_LINE_EVENT_FLAGS:
        next_rdata[6:0] = line_event_flags;
      `UIM_OFF_FLAG_HOLD_SELECT:
        next_rdata[6:0] = flag_hold_bits;
      `UIM_OFF_EVENT_PORT_MASKS:
        next_rdata = event_port_masks;
      `UIM_OFF_FRAME_START_COUNTER:
        next_rdata[10:0] = frame_counter;                        // [R14]
      `UIM_OFF_LAST_PACKET_ID:
        next_rdata[3:0] = last_packet_id_field;                  // [R15]
      `UIM_OFF_LAST_ENDPOINT:
        next_rdata[4:0] = {endpoint_valid_bit, endpoint_number_field};
      `UIM_OFF_SPECIAL_ENDPOINT_SEL:
        next_rdata[15:0] = special_endpoint_bits;
      `UIM_OFF_OTG_STATUS_MASK:
        next_rdata = otg_mask_reg;
      `UIM_OFF_POWER_SIGNALLING:
        next_rdata[8:0] = {power_valid_reg, power_data_reg};     // [R19]
      default:
        next_rdata = `UIM_RESET_ZERO;                            // [R20]
    endcase
  end

  // Read data answers one edge after the request and holds until the next.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= `UIM_RESET_ZERO;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;                                    // [R18]
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end

endmodule // uim_status_bank

`default_nettype wire

// ==== dv/uim_status_bank_assertions.sv ====
// Purpose: Port-level assertions for the USB status bank.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Bound to every instance of uim_status_bank.
`timescale 1ns/1ps
`default_nettype none

module uim_status_bank_assertions
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst,
  // Register port.
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Serial transmit controls.
  input wire logic        utmi_tx_se0,
  input wire logic        utmi_tx_data,
  input wire logic        utmi_tx_enable_n,
  input wire logic        utmi_fsls_serial,
  // Capture and register copies.
  input wire logic        endpoint_strobe,
  input wire logic [3:0]  endpoint_value,
  input wire logic [4:0]  rx_endpoint_tag,
  input wire logic        frame_strobe,
  input wire logic [10:0] frame_number,
  input wire logic [10:0] frame_count,
  input wire logic [7:0]  power_signal_data,
  input wire logic        power_signal_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Decoded writes; the serial outputs may only move on one of these.
  wire wr_ser = reg_write && (reg_addr == 8'h18);
  wire wr_pwr = reg_write && (reg_addr == 8'h3C);

  a_read_answer: assert property (reg_read |=> reg_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved");
  a_serial_drive: assert property (wr_ser |=>
    {utmi_tx_se0, utmi_tx_data} == $past(reg_wdata[3:2]))
    else $error("transmit pins wrong");
  a_mode_drive: assert property (wr_ser |=>
    {utmi_tx_enable_n, utmi_fsls_serial} == $past(reg_wdata[1:0]))
    else $error("enable or mode pin wrong");
  a_serial_hold: assert property (!wr_ser |=>
    $stable({utmi_tx_se0, utmi_tx_data, utmi_tx_enable_n}))
    else $error("serial pins moved");
  a_tag_capture: assert property (endpoint_strobe |=>
    rx_endpoint_tag[3:0] == $past(endpoint_value))
    else $error("endpoint tag wrong");
  a_frame_load: assert property (frame_strobe |=>
    frame_count == $past(frame_number))
    else $error("frame counter not loaded");
  a_power_store: assert property (wr_pwr |=>
    {power_signal_valid, power_signal_data} == $past(reg_wdata[8:0]))
    else $error("power not stored");
endmodule // uim_status_bank_assertions

bind uim_status_bank uim_status_bank_assertions u_chk (.*);

`default_nettype wire

// ==== dv/uim_phy_model.sv ====
// Purpose: Behavioural UTMI+ transceiver driving the bank's pins.
// Assumes: Bench sets session flags and idle line levels directly.
// Notes:   In serial mode the sent symbol loops back onto receive.
`timescale 1ns/1ps
`default_nettype none

module uim_phy_model
(
  // Clock and {se0, data, enable_n, fsls} from the bank.
  input  wire logic       clock,
  input  wire logic [3:0] tx_ctl,
  // Bench commands: {line_state, rx_active, rx_error}.
  input  wire logic [5:0] otg_cmd,
  input  wire logic [3:0] rx_cmd,
  // Transceiver pins.
  output var  logic [5:0] otg_pins,
  output var  logic [2:0] rx_lines,
  output var  logic [1:0] line_state,
  output var  logic [1:0] rx_flags
);
  // Loopback only while transmitting keeps idle lines under bench control.
  always @(posedge clock)
  begin
    otg_pins <= otg_cmd;
    rx_flags <= rx_cmd[1:0];
    if (tx_ctl[0] && !tx_ctl[1])
    begin
      rx_lines   <= tx_ctl[3] ? 3'h0 : {tx_ctl[2], !tx_ctl[2], tx_ctl[2]};
      line_state <= tx_ctl[3] ? 2'h0 : (tx_ctl[2] ? 2'h1 : 2'h2);
    end
    else
    begin
      rx_lines   <= 3'h0;
      line_state <= rx_cmd[3:2];
    end
  end
endmodule // uim_phy_model

`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the USB status bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Idle line state 3 sets no line flag.
`timescale 1ns/1ps
`default_nettype none

module automatic tb;
  logic clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic packet_start = 1'b0, token_strobe = 1'b0, data_crc16_fail = 1'b0;
  logic token_crc5_ok = 1'b1, token_pid_ok = 1'b1, frame_strobe = 1'b0;
  logic pid_strobe = 1'b0, endpoint_strobe = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [6:0] token_address = 7'h0, device_address = 7'h15;
  logic [3:0] pid_value = 4'h0, endpoint_value = 4'h0, rx_cmd = 4'hC;
  logic [10:0] frame_number = 11'h0;
  logic [5:0] otg_cmd = 6'h0;
  wire logic [31:0] reg_rdata, otg_mask_value;
  wire logic reg_rvalid, utmi_tx_se0, utmi_tx_data, utmi_tx_enable_n;
  wire logic utmi_fsls_serial, event_port_a, event_port_b, event_port_c;
  wire logic event_port_d, power_signal_valid, utmi_rx_active;
  wire logic utmi_session_end, utmi_session_valid, utmi_vbus_valid;
  wire logic utmi_host_disconnect, utmi_id_ground, utmi_b_valid;
  wire logic utmi_rx_rcv, utmi_rx_dm, utmi_rx_dp, utmi_rx_error;
  wire logic [1:0] utmi_line_state;
  wire logic [4:0] rx_endpoint_tag;
  wire logic [10:0] frame_count;
  wire logic [7:0] power_signal_data;
  int bad_count = 0, total_checks = 0;
  logic [31:0] full [12] = '{32'h0, 32'hF, 32'h0, 32'h7F, 32'hFFFFFFFF,
    32'h7FF, 32'h0, 32'h0, 32'hFFFF, 32'hFFFFFFFF, 32'h1FF, 32'h0};

  uim_status_bank DUT (.*);
  uim_phy_model u_phy (.clock(clock), .otg_cmd(otg_cmd), .rx_cmd(rx_cmd),
    .tx_ctl({utmi_tx_se0, utmi_tx_data, utmi_tx_enable_n, utmi_fsls_serial}),
    .otg_pins({utmi_b_valid, utmi_id_ground, utmi_host_disconnect,
               utmi_vbus_valid, utmi_session_valid, utmi_session_end}),
    .rx_lines({utmi_rx_rcv, utmi_rx_dm, utmi_rx_dp}),
    .line_state(utmi_line_state), .rx_flags({utmi_rx_active, utmi_rx_error}));

  // Clock at 200 MHz.
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  task end_of_test;
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Full-word accesses; an idle edge after each keeps strobes single-step.
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
    tick(1);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    check({31'h0, reg_rvalid}, 32'h1);
    check(reg_rdata, exp);
    tick(1);
  endtask

  task ports(input logic [3:0] exp);
    check({28'h0, event_port_a, event_port_b, event_port_c, event_port_d},
      {28'h0, exp});
  endtask

  // Reset values, then all-ones writes including the unmapped 0x40.
  task t_regs;
    for (int i = 0; i < 12; i++)
      rd(8'(8'h14 + i * 4), (i == 1) ? 32'h2 : 32'h0);
    for (int i = 0; i < 12; i++)
      wr(8'(8'h14 + i * 4), 32'hFFFFFFFF);
    for (int i = 0; i < 12; i++)
      rd(8'(8'h14 + i * 4), full[i]);
    for (int i = 0; i < 12; i++)
      wr(8'(8'h14 + i * 4), (i == 1) ? 32'h2 : 32'h0);
  endtask

  task t_otg;
    for (int i = 0; i < 2; i++)
    begin
      otg_cmd = i ? 6'h15 : 6'h2A;
      tick(4);
      rd(8'h14, i ? 32'h15 : 32'h2A);
    end
  endtask

  // Looped-back J, K and SE0 show in serial bits and line flags.
  task t_serial;
    logic [7:0] ctl [3] = '{8'h05, 8'h01, 8'h09};
    logic [7:0] ser [3] = '{8'h55, 8'h21, 8'h09};
    logic [7:0] flg [3] = '{8'h08, 8'h10, 8'h20};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h18, {24'h0, ctl[i]});
      tick(5);
      rd(8'h18, {24'h0, ser[i]});
      rd(8'h1C, {24'h0, flg[i]});
    end
    wr(8'h18, 32'h2);
    tick(5);
  endtask

  task token(input logic [6:0] adr);
    token_address = adr;
    token_strobe = 1'b1;
    tick(1);
    token_strobe = 1'b0;
  endtask

  task pkt;
    packet_start = 1'b1;
    tick(1);
    packet_start = 1'b0;
  endtask

  task t_flags;
    wr(8'h24, 32'h01020440);
    token(7'h14);
    rd(8'h1C, 32'h0);
    token(7'h15);
    tick(1);
    ports(4'h8);
    rd(8'h1C, 32'h40);
    pkt;
    rd(8'h1C, 32'h0);
    wr(8'h20, 32'h44);
    token(7'h15);
    data_crc16_fail = 1'b1;
    tick(1);
    data_crc16_fail = 1'b0;
    pkt;
    rd(8'h1C, 32'h44);
    ports(4'hC);
    wr(8'h1C, 32'h40);
    rd(8'h1C, 32'h04);
    rx_cmd = 4'hF;
    tick(5);
    rd(8'h1C, 32'h07);
    ports(4'h7);
    rx_cmd = 4'hC;
    tick(5);
    rd(8'h1C, 32'h04);
  endtask

  // Endpoint 5 is marked special, endpoint 3 is not.
  task t_capture;
    wr(8'h34, 32'h20);
    for (int i = 0; i < 2; i++)
    begin
      pid_value = 4'h9;
      endpoint_value = i ? 4'h3 : 4'h5;
      pid_strobe = 1'b1;
      endpoint_strobe = 1'b1;
      tick(1);
      pid_strobe = 1'b0;
      endpoint_strobe = 1'b0;
      check({27'h0, rx_endpoint_tag}, i ? 32'h03 : 32'h15);
      rd(8'h30, i ? 32'h13 : 32'h15);
    end
    rd(8'h2C, 32'h9);
    frame_number = 11'h5A5;
    frame_strobe = 1'b1;
    tick(1);
    frame_strobe = 1'b0;
    rd(8'h28, 32'h5A5);
  endtask

  // Main sequence after 12 reset cycles.
  initial
  begin
    tick(12);
    rst = 1'b0;
    t_regs;
    t_otg;
    t_serial;
    t_flags;
    t_capture;
    end_of_test;
  end

  // Watchdog far beyond the test length.
  initial
  begin
    #100000;
    bad_count++;
    end_of_test;
  end
endmodule // tb

`default_nettype wire
